// [inc/fault_retry_pkg.sv]
// Shared constants and types for the fault response and restart sequencer
package fault_retry_pkg;

	// ****************************************
	// Handling byte layout
	// ****************************************
	localparam int         CFG_W          = 8;
	localparam int         RESP_MSB       = 7;
	localparam int         RESP_LSB       = 6;
	localparam int         RETRY_MSB      = 5;
	localparam int         RETRY_LSB      = 3;
	localparam int         DELAY_MSB      = 2;
	localparam int         DELAY_LSB      = 0;
	localparam logic [7:0] CFG_RESET      = 8'h80;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] RESP_IGNORE    = 2'h0;
	localparam logic [1:0] RESP_DELAYED   = 2'h1;
	localparam logic [1:0] RESP_DISABLE   = 2'h2;
	localparam logic [1:0] RESP_HOLD_OFF  = 2'h3;
	localparam logic [2:0] RETRY_NONE     = 3'h0;
	localparam logic [2:0] RETRY_FOREVER  = 3'h7;

	// ****************************************
	// Timing widths
	// ****************************************
	localparam int         UNIT_TICKS_W   = 16;
	localparam int         UNIT_CNT_W     = 8;

	typedef struct packed {
		logic [1:0] response;
		logic [2:0] retries;
		logic [2:0] delayExp;
	} cfg_t;

	typedef enum logic [2:0] {
		SEQ_RUN,
		SEQ_DELAY,
		SEQ_RETRY_WAIT,
		SEQ_HOLD,
		SEQ_LATCHED,
		SEQ_CMD_OFF
	} seq_state_t;

	typedef struct packed {
		logic                     start;
		logic [2:0]               delayExp;
		logic [UNIT_TICKS_W-1:0]  unitTicks;
	} timer_req_t;

endpackage

// [core/fault_retry_timer.sv]
// Delay timer counting 2^n delay units of a programmable tick length
module fault_retry_timer (
	input  wire logic                       core_clk,
	input  wire logic                       rstSync_n,
	input  wire fault_retry_pkg::timer_req_t req,
	output logic                            busy,
	output logic                            done
);

	typedef struct packed {
		logic                                   busy;
		logic                                   done;
		logic [fault_retry_pkg::UNIT_TICKS_W-1:0] tick;
		logic [fault_retry_pkg::UNIT_CNT_W-1:0]   unit;
		logic [2:0]                             delayExp;
	} tmr_t;

	tmr_t tmr_r;
	tmr_t tmr_nxt;

	// Last unit index of a run of 2^n units
	function automatic logic [7:0] lastUnit(input logic [2:0] e);
		lastUnit = 8'((9'h001 << e) - 9'h001);
	endfunction

	always_comb begin
		tmr_nxt      = tmr_r;
		tmr_nxt.done = 1'b0;
		if (req.start) begin
			// A fresh start always restarts the count from zero
			tmr_nxt.busy     = 1'b1;
			tmr_nxt.tick     = '0;
			tmr_nxt.unit     = '0;
			tmr_nxt.delayExp = req.delayExp;
		end else if (tmr_r.busy) begin
			// A zero unit length is treated as one cycle
			if (tmr_r.tick + 16'h0001 >= req.unitTicks) begin
				tmr_nxt.tick = '0;
				if (tmr_r.unit == lastUnit(tmr_r.delayExp)) begin
					tmr_nxt.busy = 1'b0;
					tmr_nxt.done = 1'b1;
				end else begin
					tmr_nxt.unit = tmr_r.unit + 8'h01;
				end
			end else begin
				tmr_nxt.tick = tmr_r.tick + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			tmr_r <= '0;
		end else begin
			tmr_r <= tmr_nxt;
		end
	end

	assign busy = tmr_r.busy;
	assign done = tmr_r.done;

endmodule

// [core/fault_response_retry.sv]
// Fault response and restart sequencer for one monitored output fault
module fault_response_retry (
	input  wire logic                                   core_clk,
	input  wire logic                                   arst_n,
	input  wire logic                                   faultIn,
	input  wire logic                                   cfgWrite,
	input  wire logic [7:0]                             cfgWrData,
	output logic      [7:0]                             cfgRdData,
	input  wire logic                                   clearStatus,
	input  wire logic                                   clearFaults,
	input  wire logic                                   outputCmdOn,
	input  wire logic                                   otherShutdown,
	input  wire logic [fault_retry_pkg::UNIT_TICKS_W-1:0] unitTicks,
	output logic                                        outputEnable,
	output logic                                        faultStatus,
	output logic                                        faultLatched,
	output logic      [2:0]                             attemptCount,
	output fault_retry_pkg::seq_state_t                 seqState
);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rstPipe_r;
	logic       rstSync_n;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe_r <= 2'h0;
		end else begin
			rstPipe_r <= {rstPipe_r[0], 1'b1};
		end
	end

	assign rstSync_n = rstPipe_r[1];

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0]                  faultSync;
		fault_retry_pkg::cfg_t       cfg;
		fault_retry_pkg::seq_state_t state;
		logic                        status;
		logic                        latched;
		logic [2:0]                  attempts;
		logic                        cmdOnPrev;
		logic                        outEn;
	} core_t;

	core_t                       core_r;
	core_t                       core_nxt;
	fault_retry_pkg::timer_req_t timerReq;
	logic                        timerBusy;
	logic                        timerDone;
	logic                        fault;
	logic                        clearEvent;
	logic                        cmdOnRise;

	// Attempts used up; the forever setting never runs out
	function automatic logic retriesSpent(input logic [2:0] limit, input logic [2:0] used);
		retriesSpent = (limit != fault_retry_pkg::RETRY_FOREVER) && (used >= limit);
	endfunction

	assign fault     = core_r.faultSync[1];
	assign cmdOnRise = outputCmdOn && !core_r.cmdOnPrev;
	// Off-then-on shows as a rising command edge
	assign clearEvent = clearStatus || clearFaults || cmdOnRise;

	fault_retry_timer u_timer (
		.core_clk  (core_clk),
		.rstSync_n (rstSync_n),
		.req       (timerReq),
		.busy      (timerBusy),
		.done      (timerDone)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		core_nxt           = core_r;
		timerReq.start     = 1'b0;
		timerReq.delayExp  = core_r.cfg.delayExp;
		timerReq.unitTicks = unitTicks;

		core_nxt.faultSync = {core_r.faultSync[0], faultIn};
		core_nxt.cmdOnPrev = outputCmdOn;
		if (cfgWrite) begin
			core_nxt.cfg = fault_retry_pkg::cfg_t'(cfgWrData);
		end

		// Status: a fault in the clearing cycle still sets it
		if (clearStatus || clearFaults) begin
			core_nxt.status = 1'b0;
		end
		if (fault) begin
			core_nxt.status = 1'b1;
		end

		case (core_r.state)
			fault_retry_pkg::SEQ_RUN: begin
				if (fault) begin
					case (core_r.cfg.response)
						fault_retry_pkg::RESP_IGNORE: begin
							core_nxt.state = fault_retry_pkg::SEQ_RUN;
						end
						fault_retry_pkg::RESP_DELAYED: begin
							core_nxt.state = fault_retry_pkg::SEQ_DELAY;
							timerReq.start = 1'b1;
						end
						fault_retry_pkg::RESP_DISABLE: begin
							core_nxt.outEn = 1'b0;
							if (core_r.cfg.retries == fault_retry_pkg::RETRY_NONE) begin
								core_nxt.state   = fault_retry_pkg::SEQ_LATCHED;
								core_nxt.latched = 1'b1;
							end else begin
								core_nxt.state = fault_retry_pkg::SEQ_RETRY_WAIT;
								timerReq.start = 1'b1;
							end
						end
						default: begin
							core_nxt.outEn = 1'b0;
							core_nxt.state = fault_retry_pkg::SEQ_HOLD;
						end
					endcase
				end
			end
			fault_retry_pkg::SEQ_DELAY: begin
				if (timerDone) begin
					if (!fault) begin
						core_nxt.state = fault_retry_pkg::SEQ_RUN;
					end else if (core_r.cfg.retries == fault_retry_pkg::RETRY_NONE) begin
						core_nxt.outEn   = 1'b0;
						core_nxt.state   = fault_retry_pkg::SEQ_LATCHED;
						core_nxt.latched = 1'b1;
					end else begin
						core_nxt.outEn = 1'b0;
						core_nxt.state = fault_retry_pkg::SEQ_RETRY_WAIT;
						timerReq.start = 1'b1;
					end
				end
			end
			fault_retry_pkg::SEQ_RETRY_WAIT: begin
				// An attempt is made each time the spacing delay runs out
				if (timerDone) begin
					if (!fault) begin
						core_nxt.outEn    = 1'b1;
						core_nxt.state    = fault_retry_pkg::SEQ_RUN;
						core_nxt.attempts = 3'h0;
					end else if (retriesSpent(core_r.cfg.retries,
							core_r.attempts + 3'h1)) begin
						core_nxt.attempts = core_r.attempts + 3'h1;
						core_nxt.state    = fault_retry_pkg::SEQ_LATCHED;
						core_nxt.latched  = 1'b1;
					end else begin
						// Saturate so the forever setting cannot wrap the count
						if (core_r.attempts != 3'h7) begin
							core_nxt.attempts = core_r.attempts + 3'h1;
						end
						timerReq.start = 1'b1;
					end
				end
			end
			fault_retry_pkg::SEQ_HOLD: begin
				if (!fault) begin
					core_nxt.outEn = 1'b1;
					core_nxt.state = fault_retry_pkg::SEQ_RUN;
				end
			end
			fault_retry_pkg::SEQ_LATCHED: begin
				if (clearEvent) begin
					core_nxt.state    = fault_retry_pkg::SEQ_RUN;
					core_nxt.latched  = 1'b0;
					core_nxt.attempts = 3'h0;
					core_nxt.outEn    = 1'b1;
				end
			end
			fault_retry_pkg::SEQ_CMD_OFF: begin
				if (outputCmdOn) begin
					core_nxt.state    = fault_retry_pkg::SEQ_RUN;
					core_nxt.latched  = 1'b0;
					core_nxt.attempts = 3'h0;
					core_nxt.outEn    = 1'b1;
				end
			end
			default: begin
				core_nxt.state = fault_retry_pkg::SEQ_LATCHED;
				core_nxt.outEn = 1'b0;
			end
		endcase

		// Off command and outside shutdown override every sequence
		if (!outputCmdOn) begin
			core_nxt.state    = fault_retry_pkg::SEQ_CMD_OFF;
			core_nxt.outEn    = 1'b0;
			core_nxt.attempts = 3'h0;
			timerReq.start    = 1'b0;
		end else if (otherShutdown) begin
			core_nxt.state   = fault_retry_pkg::SEQ_LATCHED;
			core_nxt.latched = 1'b1;
			core_nxt.outEn   = 1'b0;
			timerReq.start   = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			core_r           <= '0;
			core_r.cfg       <= fault_retry_pkg::cfg_t'(fault_retry_pkg::CFG_RESET);
			core_r.state     <= fault_retry_pkg::SEQ_CMD_OFF;
			// Idle level of the on command, so reset shows no false edge
			core_r.cmdOnPrev <= 1'b1;
		end else begin
			core_r <= core_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cfgRdData    = core_r.cfg;
	assign outputEnable = core_r.outEn;
	assign faultStatus  = core_r.status;
	assign faultLatched = core_r.latched;
	assign attemptCount = core_r.attempts;
	assign seqState     = core_r.state;

endmodule

// [testbench/fault_retry_props.sv]
// Port checks for the fault response and restart sequencer
module fault_retry_props (
	input wire logic                        core_clk,
	input wire logic                        arst_n,
	input wire logic                        faultIn,
	input wire logic                        cfgWrite,
	input wire logic [7:0]                  cfgRdData,
	input wire logic                        clearStatus,
	input wire logic                        clearFaults,
	input wire logic                        outputCmdOn,
	input wire logic                        otherShutdown,
	input wire logic                        outputEnable,
	input wire logic                        faultLatched,
	input wire logic [2:0]                  attemptCount,
	input wire fault_retry_pkg::seq_state_t seqState
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic run;
	assign run = outputCmdOn && !otherShutdown;
	chk_off_wins: assert property (!outputCmdOn |=>
		!outputEnable && seqState == fault_retry_pkg::SEQ_CMD_OFF) else $error("off ignored");
	chk_other_shut: assert property (outputCmdOn && otherShutdown |=>
		faultLatched && !outputEnable) else $error("shutdown ignored");
	chk_ignore_on: assert property (run && !cfgWrite && cfgRdData[7:6] == 2'h0 &&
		seqState == fault_retry_pkg::SEQ_RUN |=> outputEnable) else $error("ignore broke");
	chk_fast_off: assert property ($rose(faultIn) && cfgRdData[7:6] == 2'h2 &&
		seqState == fault_retry_pkg::SEQ_RUN |-> ##3 !outputEnable) else $error("slow off");
	chk_latch_off: assert property (faultLatched |-> !outputEnable)
		else $error("latched but on");
	chk_hold_off: assert property (seqState == fault_retry_pkg::SEQ_HOLD |->
		!outputEnable && !faultLatched) else $error("hold wrong");
	chk_retry_forever: assert property (run && !cfgWrite && cfgRdData[5:3] == 3'h7 &&
		seqState != fault_retry_pkg::SEQ_LATCHED |=> !faultLatched) else $error("latched");
	chk_clear_latch: assert property (seqState == fault_retry_pkg::SEQ_LATCHED &&
		run && (clearStatus || clearFaults) |=> outputEnable && attemptCount == 3'h0
		&& !faultLatched) else $error("clear failed");
	cover property (faultLatched && attemptCount == 3'h6);
	cover property (seqState == fault_retry_pkg::SEQ_HOLD);
	cover property (attemptCount == 3'h7);
endmodule
bind fault_response_retry fault_retry_props fault_retry_props_i (
	.core_clk(core_clk), .arst_n(arst_n), .faultIn(faultIn), .cfgWrite(cfgWrite),
	.cfgRdData(cfgRdData), .clearStatus(clearStatus), .clearFaults(clearFaults),
	.outputCmdOn(outputCmdOn), .otherShutdown(otherShutdown), .outputEnable(outputEnable),
	.faultLatched(faultLatched), .attemptCount(attemptCount), .seqState(seqState)
);

// [testbench/fault_host_model.sv]
// Host model: handling byte writes, fault clears and the on/off command
module fault_host_model (
	input  wire logic core_clk,
	output logic      cfgWrite,
	output logic [7:0] cfgWrData,
	output logic      clearStatus,
	output logic      clearFaults,
	output logic      outputCmdOn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cfgWrite = 1'b0;
		cfgWrData = 8'h00;
		clearStatus = 1'b0;
		clearFaults = 1'b0;
		outputCmdOn = 1'b1;
	end
	task automatic write_cfg(input logic [7:0] b);
		@(posedge core_clk);
		cfgWrite <= 1'b1;
		cfgWrData <= b;
		@(posedge core_clk);
		cfgWrite <= 1'b0;
	endtask
	// Kind 2 is a one-cycle off, then on again
	task automatic clear_fault(input int kind);
		@(posedge core_clk);
		clearStatus <= (kind == 0);
		clearFaults <= (kind == 1);
		outputCmdOn <= (kind < 2);
		@(posedge core_clk);
		clearStatus <= 1'b0;
		clearFaults <= 1'b0;
		outputCmdOn <= 1'b1;
	endtask
	task automatic set_on(input logic v);
		@(posedge core_clk);
		outputCmdOn <= v;
	endtask
endmodule

// [testbench/fault_response_retry_bench.sv]
// Self-checking bench for the fault response and restart sequencer
module fault_response_retry_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, arst_n, faultIn, otherShutdown, cfgWrite, clearStatus, clearFaults;
	logic outputCmdOn, outputEnable, faultStatus, faultLatched, lost;
	logic [7:0] cfgWrData, cfgRdData, cfg;
	logic [2:0] attemptCount;
	logic [fault_retry_pkg::UNIT_TICKS_W-1:0] unitTicks;
	logic [31:0] rnd;
	fault_retry_pkg::seq_state_t seqState;
	int n_errors, total_checks, c, dly;
	fault_response_retry fault_response_retry_i (
		.core_clk(core_clk), .arst_n(arst_n), .faultIn(faultIn), .cfgWrite(cfgWrite),
		.cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .clearStatus(clearStatus),
		.clearFaults(clearFaults), .outputCmdOn(outputCmdOn), .otherShutdown(otherShutdown),
		.unitTicks(unitTicks), .outputEnable(outputEnable), .faultStatus(faultStatus),
		.faultLatched(faultLatched), .attemptCount(attemptCount), .seqState(seqState)
	);
	fault_host_model fault_host_model_i (
		.core_clk(core_clk), .cfgWrite(cfgWrite), .cfgWrData(cfgWrData),
		.clearStatus(clearStatus), .clearFaults(clearFaults), .outputCmdOn(outputCmdOn)
	);
	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction
	function automatic int expDelay(input int u, input int n);
		return u << n;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic check_range(input int got, input int lo, input int hi, input string what);
		total_checks++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("MISMATCH t=%0t %s took %0d", $time, what, got);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Bounded so a stuck sequencer ends the run
	task automatic wait_sig(input logic lat, input logic lvl, output int n);
		n = 0;
		while ((lat ? faultLatched : outputEnable) !== lvl && n < 3000) begin
			tick(1);
			n++;
		end
		if (n >= 3000) begin
			n_errors++;
			$display("MISMATCH t=%0t wait ran out", $time);
			complete_run();
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		arst_n = 1'b0;
		faultIn = 1'b0;
		otherShutdown = 1'b0;
		unitTicks = 16'h0001;
		rnd = 32'h51d03471;
		n_errors = 0;
		total_checks = 0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		tick(4);
		check(cfgRdData, fault_retry_pkg::CFG_RESET, "reset byte");
		check(outputEnable, 1'b1, "on after reset");
		for (int r = 0; r < 7; r++) begin
			rnd = nextRnd(rnd);
			cfg = {2'h2, r[2:0], 1'b0, rnd[1:0]};
			dly = expDelay(rnd[3:2] + 1, rnd[1:0]);
			@(posedge core_clk) unitTicks <= 16'(rnd[3:2]) + 16'h0001;
			fault_host_model_i.write_cfg(cfg);
			tick(0);
			check(cfgRdData, cfg, "readback");
			@(posedge core_clk) faultIn <= 1'b1;
			tick(0);
			wait_sig(1'b1, 1'b1, c);
			check(attemptCount, r[2:0], "attempts");
			if (r > 0) check_range(c, r * dly, r * (dly + 4) + 6, "spacing");
			@(posedge core_clk) faultIn <= 1'b0;
			tick(4);
			fault_host_model_i.clear_fault(r % 3);
			tick(2);
			check(outputEnable, 1'b1, "on after clear");
			check(attemptCount, 3'h0, "count cleared");
			if (r % 3 < 2) check(faultStatus, 1'b0, "status cleared");
		end
		// Random chatter, ending high, must never drop the output
		fault_host_model_i.write_cfg(8'h00);
		lost = 1'b0;
		for (int i = 0; i < 20; i++) begin
			rnd = nextRnd(rnd);
			@(posedge core_clk) faultIn <= rnd[0] | (i > 14);
			#1 lost = lost | !outputEnable;
		end
		check(lost, 1'b0, "ignored fault");
		check(faultStatus, 1'b1, "status set");
		fault_host_model_i.write_cfg(8'hc0);
		tick(6);
		check(seqState, fault_retry_pkg::SEQ_HOLD, "hold state");
		@(posedge core_clk) faultIn <= 1'b0;
		tick(0);
		wait_sig(1'b0, 1'b1, c);
		check_range(c, 2, 6, "resume");
		@(posedge core_clk) unitTicks <= 16'h0002;
		fault_host_model_i.write_cfg(8'h42);
		@(posedge core_clk) faultIn <= 1'b1;
		tick(0);
		wait_sig(1'b0, 1'b0, c);
		check_range(c, expDelay(2, 2), expDelay(2, 2) + 8, "run on");
		tick(2);
		check(faultLatched, 1'b1, "no retry");
		@(posedge core_clk) faultIn <= 1'b0;
		tick(4);
		fault_host_model_i.clear_fault(1);
		@(posedge core_clk) unitTicks <= 16'h0001;
		fault_host_model_i.write_cfg(8'hb8);
		@(posedge core_clk) faultIn <= 1'b1;
		tick(150);
		check(faultLatched, 1'b0, "never latches");
		check(attemptCount, 3'h7, "count saturates");
		fault_host_model_i.set_on(1'b0);
		tick(2);
		check(seqState, fault_retry_pkg::SEQ_CMD_OFF, "off stops");
		fault_host_model_i.set_on(1'b1);
		@(posedge core_clk) otherShutdown <= 1'b1;
		tick(2);
		check(faultLatched, 1'b1, "other shutdown");
		// A standing shutdown must beat a clear; a dropped one lets it through
		rnd = nextRnd(rnd);
		@(posedge core_clk) otherShutdown <= rnd[0];
		fault_host_model_i.clear_fault(1);
		tick(2);
		check(faultLatched, rnd[0], "shutdown persists");
		complete_run();
	end
endmodule
